// file: port_ctl_pkg.sv
package port_ctl_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses within one port's block)
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_IRQ_GATE   = 12'h01f;
	localparam logic [11:0] ADDR_OP_CTRL    = 12'h020;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h01b;

	localparam int NUM_PORTS  = 7;
	localparam int SGMII_PORT = 7;
	localparam int PHY_PORTS  = 5;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int GATE_SGMII_BIT = 3;
	localparam int GATE_PTP_BIT   = 2;
	localparam int GATE_PHY_BIT   = 1;
	localparam int GATE_ACL_BIT   = 0;

	localparam int CTRL_LOCAL_LB_BIT  = 7;
	localparam int CTRL_REMOTE_LB_BIT = 6;
	localparam int CTRL_TAIL_TAG_BIT  = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0] GATE_RESET   = 4'h0;
	localparam logic [1:0] QUEUE_RESET  = 2'h0;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	typedef enum logic [1:0]
	{
		QUEUE_ONE      = 2'b00,
		QUEUE_TWO      = 2'b01,
		QUEUE_FOUR     = 2'b10,
		QUEUE_RESERVED = 2'b11
	} queue_split_e;

endpackage

// file: port_irq_gate.sv
`timescale 1ns/10ps
// one port's mask register, sticky status and interrupt gating
module port_irq_gate
	import port_ctl_pkg::*;
#(
	parameter int PORT_NUM = 1
)
(
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_gate_we,
	input  wire logic [3:0] i_gate_wdata,
	input  wire logic [3:0] i_event,
	output logic      [3:0] o_gate,
	output logic      [3:0] o_status,
	output logic            o_irq
);

	// ------------------------------------------------------------
	// which mask bits exist on this port
	// ------------------------------------------------------------
	localparam logic HAS_SGMII = (PORT_NUM == SGMII_PORT);
	localparam logic HAS_PHY   = (PORT_NUM <= PHY_PORTS);
	localparam logic [3:0] IMPL = {HAS_SGMII, HAS_PHY, HAS_PHY, 1'b1};

	logic [3:0] gate_reg;
	logic [3:0] status_reg;
	logic [3:0] status_next;
	logic       acl_toggle;
	logic       irq_reg;

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			gate_reg <= GATE_RESET; // RL2
		else if (i_gate_we)
			gate_reg <= i_gate_wdata & IMPL; // RL3 RL4 RL5
	end

	assign acl_toggle = i_gate_we &&
		(i_gate_wdata[GATE_ACL_BIT] != gate_reg[GATE_ACL_BIT]);

	// the acl bit clears on a mask toggle; a new event in that cycle wins
	always_comb
	begin
		status_next = status_reg;
		if (acl_toggle)
			status_next[GATE_ACL_BIT] = 1'b0; // RL6
		status_next = status_next | (i_event & IMPL);
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			status_reg <= STATUS_RESET[3:0];
		else
			status_reg <= status_next;
	end

	// zero in the mask enables the source
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(status_next & ~gate_reg & IMPL); // RL1 RL2 RL15
	end

	assign o_gate   = gate_reg;
	assign o_status = status_reg;
	assign o_irq    = irq_reg;

endmodule

// file: port_op_ctrl.sv
`timescale 1ns/10ps
// one port's operation control register and loopback steering
module port_op_ctrl
	import port_ctl_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_we,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_ctrl,
	output logic            o_local_lb,
	output logic            o_remote_lb,
	output logic            o_tail_tag,
	output logic      [1:0] o_queue_split
);

	logic       local_lb_reg;
	logic       remote_lb_reg;
	logic       tail_tag_reg;
	logic [1:0] queue_reg;

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			local_lb_reg  <= 1'b0; // RL7
			remote_lb_reg <= 1'b0; // RL8
			tail_tag_reg  <= 1'b0; // RL11
			queue_reg     <= QUEUE_RESET; // RL13
		end
		else if (i_we)
		begin
			local_lb_reg  <= i_wdata[CTRL_LOCAL_LB_BIT]; // RL7
			remote_lb_reg <= i_wdata[CTRL_REMOTE_LB_BIT]; // RL8
			tail_tag_reg  <= i_wdata[CTRL_TAIL_TAG_BIT]; // RL11
			queue_reg     <= i_wdata[1:0]; // RL13
		end
	end

	// reserved bits 5:3 never stored and read as zero
	assign o_ctrl = {local_lb_reg, remote_lb_reg, 3'h0, tail_tag_reg, queue_reg}; // RL14
	assign o_local_lb    = local_lb_reg;
	assign o_remote_lb   = remote_lb_reg;
	assign o_tail_tag    = tail_tag_reg;
	// reserved code behaves as a single queue
	assign o_queue_split = (queue_reg == QUEUE_RESERVED) ? QUEUE_ONE : queue_reg; // RL13

endmodule

// file: port_irq_mask_and_op_control.sv
`timescale 1ns/10ps
// Behaviour
// RL1 - a port interrupt source reaches the interrupt output only when its mask bit permits it.
// RL2 - a mask bit of zero enables its interrupt, one disables it, and all reset to zero.
// RL3 - mask bit 3 for sgmii auto-negotiation done acts only on port 7.
// RL4 - mask bits 2 (timing protocol) and 1 (phy) act only on integrated-phy ports.
// RL5 - mask bit 0 for the access-control-list interrupt acts on every port.
// RL6 - software clears the access-control-list status by toggling its mask bit.
// RL7 - control bit 7 turns egress frames around in the mac back to the fabric.
// RL8 - control bit 6 loops frames from the port pins back out the same port.
// RL9 - in remote loopback phy ports go rx pair to tx pair, mac ports txd to rxd.
// RL10 - remote loopback has no elastic buffer so users send only small frames.
// RL11 - control bit 2 enables tail tagging and makes the port the host port.
// RL12 - software enables tail tagging on at most one port.
// RL13 - bits 1:0 pick one, two or four egress queues, with 11 reserved and reset 00.
// RL14 - reserved mask bits 7:4 and control bits 5:3 read zero and ignore writes.
// RL15 - the port interrupt is high while any status bit is set with its mask bit zero.
module port_irq_mask_and_op_control
	import port_ctl_pkg::*;
(
	input  wire logic                 i_mclk,
	input  wire logic                 i_rst,
	input  wire logic [2:0]           i_port_sel,
	input  wire logic [11:0]          i_addr,
	input  wire logic [7:0]           i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	input  wire logic [NUM_PORTS-1:0] i_sgmii_an_done,
	input  wire logic [NUM_PORTS-1:0] i_ptp_event,
	input  wire logic [NUM_PORTS-1:0] i_phy_event,
	input  wire logic [NUM_PORTS-1:0] i_acl_event,
	output logic      [7:0]           o_rdata,
	output logic      [NUM_PORTS-1:0] o_port_irq,
	output logic                      o_irq,
	output logic      [NUM_PORTS-1:0] o_local_lb,
	output logic      [NUM_PORTS-1:0] o_remote_lb,
	output logic      [NUM_PORTS-1:0] o_tail_tag,
	output logic      [2*NUM_PORTS-1:0] o_queue_split
);

	// ------------------------------------------------------------
	// decode: i_port_sel carries port number 1..7
	// ------------------------------------------------------------
	logic [NUM_PORTS-1:0] gate_we;
	logic [NUM_PORTS-1:0] ctrl_we;
	logic [3:0]           gate_q   [NUM_PORTS];
	logic [3:0]           status_q [NUM_PORTS];
	logic [7:0]           ctrl_q   [NUM_PORTS];
	logic [NUM_PORTS-1:0] irq_w;
	logic [NUM_PORTS-1:0] local_w;
	logic [NUM_PORTS-1:0] remote_w;
	logic [NUM_PORTS-1:0] tail_w;
	logic [1:0]           queue_w  [NUM_PORTS];
	logic [7:0]           rdata_next;
	logic [7:0]           rdata_reg;
	logic                 irq_reg;
	logic [NUM_PORTS-1:0] port_irq_reg;
	logic [NUM_PORTS-1:0] local_reg;
	logic [NUM_PORTS-1:0] remote_reg;
	logic [NUM_PORTS-1:0] tail_reg;
	logic [2*NUM_PORTS-1:0] queue_reg;
	logic                 sel_ok;
	logic [2:0]           idx;

	assign sel_ok = (i_port_sel != 3'h0);
	assign idx    = i_port_sel - 3'h1;

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++)
		begin : g_port
			assign gate_we[p] = i_wr && sel_ok && (idx == 3'(p)) && (i_addr == ADDR_IRQ_GATE);
			assign ctrl_we[p] = i_wr && sel_ok && (idx == 3'(p)) && (i_addr == ADDR_OP_CTRL);

			port_irq_gate #(
				.PORT_NUM (p + 1)
			) u_gate (
				.i_mclk       (i_mclk),
				.i_rst        (i_rst),
				.i_gate_we    (gate_we[p]),
				.i_gate_wdata (i_wdata[3:0]), // RL14
				.i_event      ({i_sgmii_an_done[p], i_ptp_event[p],
				                i_phy_event[p], i_acl_event[p]}),
				.o_gate       (gate_q[p]),
				.o_status     (status_q[p]),
				.o_irq        (irq_w[p])
			);

			port_op_ctrl u_ctrl (
				.i_mclk        (i_mclk),
				.i_rst         (i_rst),
				.i_we          (ctrl_we[p]),
				.i_wdata       (i_wdata),
				.o_ctrl        (ctrl_q[p]),
				.o_local_lb    (local_w[p]),
				.o_remote_lb   (remote_w[p]),
				.o_tail_tag    (tail_w[p]),
				.o_queue_split (queue_w[p])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// read path: data stand the cycle after the strobe only
	// ------------------------------------------------------------
	always_comb
	begin
		rdata_next = 8'h00;
		if (i_rd && sel_ok && idx < 3'(NUM_PORTS))
		begin
			case (i_addr)
				ADDR_IRQ_GATE:   rdata_next = {4'h0, gate_q[idx]}; // RL14
				ADDR_OP_CTRL:    rdata_next = ctrl_q[idx];
				ADDR_IRQ_STATUS: rdata_next = {4'h0, status_q[idx]};
				default:         rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	// ------------------------------------------------------------
	// outputs registered; the per-port irq is already a flop in the gate
	// ------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			port_irq_reg <= '0;
			irq_reg      <= 1'b0;
		end
		else
		begin
			port_irq_reg <= irq_w; // RL15
			irq_reg      <= |irq_w; // RL1
		end
	end

	// loop steering: the mac datapath consumes these; no elastic buffer exists
	// so software must keep remote-loop traffic small
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			local_reg  <= '0;
			remote_reg <= '0;
			tail_reg   <= '0;
			queue_reg  <= '0;
		end
		else
		begin
			local_reg  <= local_w; // RL7
			remote_reg <= remote_w; // RL8 RL9 RL10
			tail_reg   <= tail_w; // RL11 RL12
			for (int i = 0; i < NUM_PORTS; i++)
				queue_reg[2*i +: 2] <= queue_w[i]; // RL13
		end
	end

	assign o_rdata       = rdata_reg;
	assign o_port_irq    = port_irq_reg;
	assign o_irq         = irq_reg;
	assign o_local_lb    = local_reg;
	assign o_remote_lb   = remote_reg;
	assign o_tail_tag    = tail_reg;
	assign o_queue_split = queue_reg;

endmodule

// file: port_irq_mask_and_op_control_assertions.sv
`timescale 1ns/10ps
module port_irq_mask_and_op_control_assertions
	import port_ctl_pkg::*;
(
	input wire logic                   i_mclk,
	input wire logic                   i_rst,
	input wire logic [2:0]             i_port_sel,
	input wire logic [11:0]            i_addr,
	input wire logic [7:0]             i_wdata,
	input wire logic                   i_wr,
	input wire logic                   i_rd,
	input wire logic [NUM_PORTS-1:0]   i_sgmii_an_done,
	input wire logic [NUM_PORTS-1:0]   i_ptp_event,
	input wire logic [NUM_PORTS-1:0]   i_phy_event,
	input wire logic [NUM_PORTS-1:0]   i_acl_event,
	input wire logic [7:0]             o_rdata,
	input wire logic [NUM_PORTS-1:0]   o_port_irq,
	input wire logic                   o_irq,
	input wire logic [NUM_PORTS-1:0]   o_local_lb,
	input wire logic [NUM_PORTS-1:0]   o_remote_lb,
	input wire logic [NUM_PORTS-1:0]   o_tail_tag,
	input wire logic [2*NUM_PORTS-1:0] o_queue_split
);
	// --------------------------------
	// helper pipeline
	// --------------------------------
	logic       wr1;
	logic       wr2;
	logic [2:0] sel2;
	logic [2:0] sel1;
	logic [7:0] dat1;
	logic [7:0] dat2;
	logic [3:0] cause;
	always_ff @(posedge i_mclk)
	begin
		wr1   <= !i_rst && i_wr && i_addr == ADDR_OP_CTRL && i_port_sel != 3'h0;
		wr2   <= !i_rst && wr1;
		sel1  <= i_port_sel;
		sel2  <= sel1;
		dat1  <= i_wdata;
		dat2  <= dat1;
		// a mask write takes three edges, counting its own, to show on the irq output
		cause <= {cause[2:0], i_wr || |{i_sgmii_an_done, i_ptp_event, i_phy_event, i_acl_event}};
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	sequence s_ctl_write;
		(i_wr && i_addr == ADDR_OP_CTRL && i_port_sel != 3'h0) ##2 1'b1;
	endsequence
	sequence s_read(logic [11:0] a);
		i_rd && i_addr == a ##1 1'b1;
	endsequence
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside a read cycle");
	a_ctrl_reserved: assert property (s_read(ADDR_OP_CTRL) |-> o_rdata[5:3] == 3'h0)
		else $error("control reserved bits read nonzero");
	a_gate_reserved: assert property (s_read(ADDR_IRQ_GATE) |-> o_rdata[7:4] == 4'h0)
		else $error("mask reserved bits read nonzero");
	a_port_unmapped: assert property ($past(i_rd && i_port_sel == 3'h0) |-> o_rdata == 8'h00)
		else $error("unmapped port read nonzero");
	a_irq_or: assert property (o_irq == |o_port_irq)
		else $error("summary irq differs from port irqs");
	a_loop_apply: assert property (s_ctl_write |->
		o_local_lb[sel2-3'h1] == dat2[7] && o_remote_lb[sel2-3'h1] == dat2[6]
		&& o_tail_tag[sel2-3'h1] == dat2[2])
		else $error("control bits not applied two edges after write");
	a_queue_apply: assert property (s_ctl_write |->
		o_queue_split[2*(sel2-3'h1)+:2] == (dat2[1:0] == 2'b11 ? 2'b00 : dat2[1:0]))
		else $error("queue split not applied");
	a_ctrl_hold: assert property (!wr2 |-> $stable({o_local_lb, o_remote_lb, o_tail_tag}))
		else $error("control outputs changed without a write");
	a_irq_cause: assert property ($rose(|o_port_irq) |-> |cause)
		else $error("irq rose without event or write");
endmodule
bind port_irq_mask_and_op_control port_irq_mask_and_op_control_assertions u_chk (.*);

// file: port_irq_mask_and_op_control_bench.sv
`timescale 1ns/10ps
module port_irq_mask_and_op_control_bench
	import port_ctl_pkg::*;
;
	logic                         i_mclk = 1'b0;
	logic                         i_rst = 1'b1;
	logic [2:0]                   i_port_sel = 3'h0;
	logic [11:0]                  i_addr = 12'h000;
	logic [7:0]                   i_wdata = 8'h00;
	logic                         i_wr = 1'b0;
	logic                         i_rd = 1'b0;
	logic [3:0][NUM_PORTS-1:0]    evs = '0;
	logic [NUM_PORTS-1:0]         i_sgmii_an_done;
	logic [NUM_PORTS-1:0]         i_ptp_event;
	logic [NUM_PORTS-1:0]         i_phy_event;
	logic [NUM_PORTS-1:0]         i_acl_event;
	logic [7:0]                   o_rdata;
	logic [NUM_PORTS-1:0]         o_port_irq;
	logic [NUM_PORTS-1:0]         o_local_lb;
	logic [NUM_PORTS-1:0]         o_remote_lb;
	logic [NUM_PORTS-1:0]         o_tail_tag;
	logic                         o_irq;
	logic [2*NUM_PORTS-1:0]       o_queue_split;
	logic [7:0]                   d;
	int                           failures = 0;
	int                           samples_checked = 0;
	assign i_sgmii_an_done = evs[3];
	assign i_ptp_event = evs[2];
	assign i_phy_event = evs[1];
	assign i_acl_event = evs[0];
	always #2 i_mclk = ~i_mclk;
	port_irq_mask_and_op_control u_dut (.*);
	// --------------------------------
	// bus and check tasks
	// --------------------------------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic access(input logic [2:0] p, input logic [11:0] a, input logic [7:0] v,
		input logic w);
		@(posedge i_mclk);
		i_port_sel <= p;
		i_addr <= a;
		i_wdata <= v;
		i_wr <= w;
		i_rd <= !w;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		#1;
	endtask
	task automatic reset_dut();
		i_rst <= 1'b1;
		repeat (6) @(posedge i_mclk);
		i_rst <= 1'b0;
	endtask
	// pulses source s on port p, optionally masked first; imp says the bit exists there
	task automatic fire(input int s, input int p, input logic m, input logic imp);
		reset_dut();
		if (m)
			access(3'(p), ADDR_IRQ_GATE, 8'h01 << s, 1'b1);
		@(posedge i_mclk);
		evs[s][p-1] <= 1'b1;
		@(posedge i_mclk);
		evs <= '0;
		repeat (3) @(posedge i_mclk);
		#1;
		check("port irq", {7'h0, o_port_irq[p-1]}, {7'h0, imp && !m});
		check("irq", {7'h0, o_irq}, {7'h0, imp && !m});
		access(3'(p), ADDR_IRQ_STATUS, 8'h00, 1'b0);
		check("status", o_rdata, {7'h0, imp} << s);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#100000;
		failures++;
		end_of_test();
	end
	initial
	begin
		reset_dut();
		for (int p = 1; p <= 7; p++)
		begin
			access(3'(p), ADDR_IRQ_GATE, 8'h00, 1'b0);
			check("gate reset", o_rdata, 8'h00);
			access(3'(p), ADDR_OP_CTRL, 8'h00, 1'b0);
			check("ctrl reset", o_rdata, 8'h00);
			access(3'(p), ADDR_IRQ_GATE, 8'hff, 1'b1);
			access(3'(p), ADDR_IRQ_GATE, 8'h00, 1'b0);
			check("gate bits", o_rdata, p == 7 ? 8'h09 : (p > 5 ? 8'h01 : 8'h07));
		end
		$display("test register reset done");
		for (int q = 0; q < 4; q++)
		begin
			// tail tag lands on one port at a time; loops are set with no traffic sent
			d = {q[0], q[1], 3'b111, q[1], 2'(q)};
			access(3'(q + 4), ADDR_OP_CTRL, d, 1'b1);
			access(3'(q + 4), ADDR_OP_CTRL, 8'h00, 1'b0);
			check("ctrl read", o_rdata, d & 8'hc7);
			@(posedge i_mclk);
			#1;
			check("ctrl outs",
				{o_local_lb[q+3], o_remote_lb[q+3], o_tail_tag[q+3], 3'h0, o_queue_split[2*q+6+:2]},
				{d[7], d[6], d[2], 3'h0, q == 3 ? 2'b00 : d[1:0]});
			access(3'(q + 4), ADDR_OP_CTRL, 8'h00, 1'b1);
		end
		$display("test control done");
		access(3'h0, ADDR_OP_CTRL, 8'hff, 1'b1);
		access(3'h2, ADDR_IRQ_STATUS, 8'hff, 1'b1);
		access(3'h0, ADDR_OP_CTRL, 8'h00, 1'b0);
		check("port 0 read", o_rdata, 8'h00);
		check("port 0 write", {1'b0, o_local_lb}, 8'h00);
		access(3'h2, ADDR_IRQ_STATUS, 8'h00, 1'b0);
		check("status write", o_rdata, 8'h00);
		access(3'h2, 12'h021, 8'h00, 1'b0);
		check("unmapped read", o_rdata, 8'h00);
		$display("test refusals done");
		fire(3, 7, 1'b0, 1'b1);
		fire(3, 1, 1'b0, 1'b0);
		fire(2, 1, 1'b0, 1'b1);
		fire(2, 6, 1'b0, 1'b0);
		fire(1, 7, 1'b0, 1'b0);
		fire(1, 2, 1'b1, 1'b1);
		access(3'h2, ADDR_IRQ_GATE, 8'h00, 1'b1);
		repeat (4) @(posedge i_mclk);
		#1;
		check("unmask irq", {7'h0, o_port_irq[1]}, 8'h01);
		fire(0, 7, 1'b0, 1'b1);
		fire(0, 6, 1'b0, 1'b1);
		access(3'h6, ADDR_IRQ_GATE, 8'h01, 1'b1);
		access(3'h6, ADDR_IRQ_STATUS, 8'h00, 1'b0);
		check("acl clear", o_rdata, 8'h00);
		check("acl irq", {7'h0, o_irq}, 8'h00);
		// unmasking again must not bring the irq back once the status is gone
		access(3'h6, ADDR_IRQ_GATE, 8'h00, 1'b1);
		repeat (2) @(posedge i_mclk);
		#1;
		check("acl rearm", {7'h0, o_irq}, 8'h00);
		$display("test interrupts done");
		end_of_test();
	end
endmodule
